// file: core/ppc_pkg.sv
// shared constants and types for the port pad config and interrupt mask block
package ppc_pkg;
    localparam int DATA_W = 8;
    localparam int P5_W   = 8;
    localparam int P6_W   = 8;
    localparam int P7_W   = 1;
    localparam int SEL_W  = 4;

    // selector codes in the I/O-control space
    localparam logic [3:0] CTL_PORT5_DIR  = 4'h5;
    localparam logic [3:0] CTL_PORT6_DIR  = 4'h6;
    localparam logic [3:0] CTL_PORT7_DIR  = 4'h7;
    localparam logic [3:0] CTL_PULL_DOWN  = 4'hB;
    localparam logic [3:0] CTL_OPEN_DRAIN = 4'hC;
    localparam logic [3:0] CTL_PULL_HIGH  = 4'hD;
    localparam logic [3:0] CTL_IRQ_MASK   = 4'hF;
    // selector codes in the operational-register space
    localparam logic [3:0] REG_PORT5      = 4'h5;
    localparam logic [3:0] REG_PORT6      = 4'h6;
    localparam logic [3:0] REG_PORT7      = 4'h7;
    localparam logic [3:0] REG_WAKE_CTL   = 4'hA;
    localparam logic [3:0] REG_IRQ_FLAGS  = 4'hF;

    // field positions
    localparam int BIT_LOW_VOLTAGE = 7;
    localparam int BIT_EXTERNAL    = 2;
    localparam int BIT_PORT_CHANGE = 1;
    localparam int BIT_TIMER_OVF   = 0;
    localparam int BIT_WAKE_EN     = 6;
    localparam int PD_P6_LSB       = 4;  // pull-down bits 7..4 -> port 6 pins 3..0
    localparam int PD_P5_LSB       = 0;  // pull-down bits 3..0 -> port 5 pins 3..0
    localparam int PD_PINS         = 4;

    // implemented bits of mask and flags; 6..3 unused
    localparam logic [7:0] IRQ_BITS_MASK  = 8'h87;
    localparam logic [7:0] WAKE_BITS_MASK = 8'h40;

    // reset values
    localparam logic [7:0] RST_DIR        = 8'hFF;
    localparam logic [7:0] RST_PULL_DOWN  = 8'hFF;
    localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;
    localparam logic [7:0] RST_PULL_HIGH  = 8'hFF;
    localparam logic [7:0] RST_IRQ_MASK   = 8'h00;
    localparam logic [7:0] RST_ZERO       = 8'h00;

    // one access from the core: ctl_space selects I/O-control registers
    typedef struct packed {
        logic             ctl_space;
        logic             wr;
        logic             rd;
        logic [SEL_W-1:0] sel;
        logic [DATA_W-1:0] wdata;
    } ppc_req_t;

    // core instruction strobes
    typedef struct packed {
        logic enable_interrupts_instr;
        logic disable_interrupts_instr;
        logic sleep;
    } ppc_instr_t;

    // hardware interrupt events, one-cycle pulses
    typedef struct packed {
        logic low_voltage;
        logic external;
        logic timer_ovf;
    } ppc_event_t;
endpackage

// file: core/ppc_port.sv
// port direction, pad config, port 6 change detect and interrupt mask logic
`timescale 1ns/1ps
// Function
// - pull-down bit 0 enables the pin pull-down, 1 disables it
// - pull-down bits 7..4 serve port 6 pins 3..0, bits 3..0 port 5 pins 3..0
// - open-drain bit n high makes port 6 pin n open-drain, else push-pull
// - pull-high bit n low enables the port 6 pin n pull-up
// - pull-down, open-drain and pull-high registers read back all eight bits
// - mask bit 7 low voltage, 2 external, 1 port change, 0 timer; 1 enables
// - a source interrupts only while its mask bit is 1
// - global enable set by enable instruction, cleared by disable, gates all sources
// - interrupt mask register is readable and writable
// - every port pin has its own direction bit
// - port 7 pin as output only pulls low, open-drain
// - port data and direction registers are readable and writable
// - change wake-up with mask bit set vectors if global enable, else continues
// - change wake-up with mask bit clear always continues after sleep
// - with global enable and mask bit, a port 6 change vectors the core
// - direction bit 1 makes the pin an input, 0 enables its driver
// - port change flag set by hardware on port 6 change, cleared by software
// - reading the flags returns flags AND mask
// - wake-control bit 6 enables wake-up on port 6 change
module ppc_port (
    input  wire logic                        mclk_i,
    input  wire logic                        rst_n_i,
    input  wire ppc_pkg::ppc_req_t           req_i,
    input  wire ppc_pkg::ppc_instr_t         instr_i,
    input  wire ppc_pkg::ppc_event_t         event_i,
    input  wire logic [ppc_pkg::P5_W-1:0]    p5_in_i,
    input  wire logic [ppc_pkg::P6_W-1:0]    p6_in_i,
    input  wire logic [ppc_pkg::P7_W-1:0]    p7_in_i,
    output logic [ppc_pkg::DATA_W-1:0]       rdata_o,
    output logic [ppc_pkg::P5_W-1:0]         p5_out_o,
    output logic [ppc_pkg::P5_W-1:0]         p5_oe_n_o,
    output logic [ppc_pkg::P6_W-1:0]         p6_out_o,
    output logic [ppc_pkg::P6_W-1:0]         p6_oe_n_o,
    output logic [ppc_pkg::P7_W-1:0]         p7_out_o,
    output logic [ppc_pkg::P7_W-1:0]         p7_oe_n_o,
    output logic [ppc_pkg::PD_PINS-1:0]      p5_pull_down_en_o,
    output logic [ppc_pkg::PD_PINS-1:0]      p6_pull_down_en_o,
    output logic [ppc_pkg::P6_W-1:0]         p6_pull_up_en_o,
    output logic                             irq_o,
    output logic                             asleep_o,
    output logic                             wake_o,
    output logic                             wake_vector_o
);
    typedef enum logic [1:0] {
        PPC_RUN   = 2'b01,
        PPC_SLEEP = 2'b10
    } ppc_state_t;

    // config and data registers
    logic [ppc_pkg::P5_W-1:0]   p5_dir_q,  p5_dir_d,  p5_dat_q,  p5_dat_d;
    logic [ppc_pkg::P6_W-1:0]   p6_dir_q,  p6_dir_d,  p6_dat_q,  p6_dat_d;
    logic [ppc_pkg::P7_W-1:0]   p7_dir_q,  p7_dir_d,  p7_dat_q,  p7_dat_d;
    logic [ppc_pkg::DATA_W-1:0] pull_down_control_q, pull_down_control_d;
    logic [ppc_pkg::DATA_W-1:0] open_drain_control_q, open_drain_control_d;
    logic [ppc_pkg::DATA_W-1:0] pull_high_control_q, pull_high_control_d;
    logic [ppc_pkg::DATA_W-1:0] interrupt_mask_q, interrupt_mask_d;
    logic [ppc_pkg::DATA_W-1:0] wake_control_q, wake_control_d;
    // flags, global enable, sleep, change detect
    logic [ppc_pkg::DATA_W-1:0] interrupt_flags_q, interrupt_flags_d;
    logic [ppc_pkg::P6_W-1:0]   p6_snap_q, p6_snap_d;
    logic                       gie_q, gie_d;
    ppc_state_t                 state_q, state_d;
    logic                       irq_q, irq_d;
    logic                       wake_q, wake_d;
    logic                       wake_vec_q, wake_vec_d;
    // registered outputs
    logic [ppc_pkg::DATA_W-1:0] rdata_q, rdata_d;
    logic [ppc_pkg::P5_W-1:0]   p5_out_q, p5_out_d, p5_oe_n_q, p5_oe_n_d;
    logic [ppc_pkg::P6_W-1:0]   p6_out_q, p6_out_d, p6_oe_n_q, p6_oe_n_d;
    logic [ppc_pkg::P7_W-1:0]   p7_out_q, p7_out_d, p7_oe_n_q, p7_oe_n_d;
    logic [ppc_pkg::PD_PINS-1:0] p5_pd_q, p5_pd_d, p6_pd_q, p6_pd_d;
    logic [ppc_pkg::P6_W-1:0]   p6_pu_q, p6_pu_d;

    logic ctl_wr, reg_wr, ctl_rd, reg_rd;
    logic change_seen;

    // true when this access names the given selector in the given space; wr and rd are not checked
    function automatic logic hit(input ppc_pkg::ppc_req_t r, input logic space, input logic [3:0] sel);
        hit = (r.ctl_space == space) && (r.sel == sel);
    endfunction

    // open-drain pin: enable drive only when output and driving low
    function automatic logic od_oe_n(input logic dir, input logic dat);
        od_oe_n = dir | dat;
    endfunction

    assign ctl_wr = req_i.wr & req_i.ctl_space;
    assign reg_wr = req_i.wr & ~req_i.ctl_space;
    assign ctl_rd = req_i.rd & req_i.ctl_space;
    assign reg_rd = req_i.rd & ~req_i.ctl_space;
    // mismatch against the last snapshot; the change flag is sticky anyway
    assign change_seen = (p6_in_i != p6_snap_q);

    // register writes, snapshot on port 6 read
    always_comb begin
        p5_dir_d = p5_dir_q;
        p6_dir_d = p6_dir_q;
        p7_dir_d = p7_dir_q;
        p5_dat_d = p5_dat_q;
        p6_dat_d = p6_dat_q;
        p7_dat_d = p7_dat_q;
        pull_down_control_d  = pull_down_control_q;
        open_drain_control_d = open_drain_control_q;
        pull_high_control_d  = pull_high_control_q;
        interrupt_mask_d     = interrupt_mask_q;
        wake_control_d       = wake_control_q;
        p6_snap_d            = p6_snap_q;
        if (ctl_wr) begin
            if (hit(req_i, 1'b1, ppc_pkg::CTL_PORT5_DIR))  p5_dir_d = req_i.wdata[ppc_pkg::P5_W-1:0];
            if (hit(req_i, 1'b1, ppc_pkg::CTL_PORT6_DIR))  p6_dir_d = req_i.wdata[ppc_pkg::P6_W-1:0];
            if (hit(req_i, 1'b1, ppc_pkg::CTL_PORT7_DIR))  p7_dir_d = req_i.wdata[ppc_pkg::P7_W-1:0];
            if (hit(req_i, 1'b1, ppc_pkg::CTL_PULL_DOWN))  pull_down_control_d  = req_i.wdata;
            if (hit(req_i, 1'b1, ppc_pkg::CTL_OPEN_DRAIN)) open_drain_control_d = req_i.wdata;
            if (hit(req_i, 1'b1, ppc_pkg::CTL_PULL_HIGH))  pull_high_control_d  = req_i.wdata;
            // unused bits 6..3 are not stored, so they read as zero
            if (hit(req_i, 1'b1, ppc_pkg::CTL_IRQ_MASK))
                interrupt_mask_d = req_i.wdata & ppc_pkg::IRQ_BITS_MASK;
        end
        if (reg_wr) begin
            if (hit(req_i, 1'b0, ppc_pkg::REG_PORT5)) p5_dat_d = req_i.wdata[ppc_pkg::P5_W-1:0];
            if (hit(req_i, 1'b0, ppc_pkg::REG_PORT6)) p6_dat_d = req_i.wdata[ppc_pkg::P6_W-1:0];
            if (hit(req_i, 1'b0, ppc_pkg::REG_PORT7)) p7_dat_d = req_i.wdata[ppc_pkg::P7_W-1:0];
            if (hit(req_i, 1'b0, ppc_pkg::REG_WAKE_CTL))
                wake_control_d = req_i.wdata & ppc_pkg::WAKE_BITS_MASK;
        end
        // a read of port 6 re-arms the change detector
        if (reg_rd && hit(req_i, 1'b0, ppc_pkg::REG_PORT6)) p6_snap_d = p6_in_i;
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            p5_dir_q <= ppc_pkg::RST_DIR[ppc_pkg::P5_W-1:0];
            p6_dir_q <= ppc_pkg::RST_DIR[ppc_pkg::P6_W-1:0];
            p7_dir_q <= ppc_pkg::RST_DIR[ppc_pkg::P7_W-1:0];
            p5_dat_q <= ppc_pkg::RST_ZERO[ppc_pkg::P5_W-1:0];
            p6_dat_q <= ppc_pkg::RST_ZERO[ppc_pkg::P6_W-1:0];
            p7_dat_q <= ppc_pkg::RST_ZERO[ppc_pkg::P7_W-1:0];
            pull_down_control_q  <= ppc_pkg::RST_PULL_DOWN;
            open_drain_control_q <= ppc_pkg::RST_OPEN_DRAIN;
            pull_high_control_q  <= ppc_pkg::RST_PULL_HIGH;
            interrupt_mask_q     <= ppc_pkg::RST_IRQ_MASK;
            wake_control_q       <= ppc_pkg::RST_ZERO;
            p6_snap_q            <= ppc_pkg::RST_ZERO[ppc_pkg::P6_W-1:0];
        end else begin
            p5_dir_q <= p5_dir_d;
            p6_dir_q <= p6_dir_d;
            p7_dir_q <= p7_dir_d;
            p5_dat_q <= p5_dat_d;
            p6_dat_q <= p6_dat_d;
            p7_dat_q <= p7_dat_d;
            pull_down_control_q  <= pull_down_control_d;
            open_drain_control_q <= open_drain_control_d;
            pull_high_control_q  <= pull_high_control_d;
            interrupt_mask_q     <= interrupt_mask_d;
            wake_control_q       <= wake_control_d;
            p6_snap_q            <= p6_snap_d;
        end
    end

    // flags, global enable, sleep and wake decisions
    always_comb begin
        logic [ppc_pkg::DATA_W-1:0] set_v;
        logic                       wake_now;
        set_v = ppc_pkg::RST_ZERO;
        set_v[ppc_pkg::BIT_LOW_VOLTAGE] = event_i.low_voltage;
        set_v[ppc_pkg::BIT_EXTERNAL]    = event_i.external;
        set_v[ppc_pkg::BIT_PORT_CHANGE] = change_seen;
        set_v[ppc_pkg::BIT_TIMER_OVF]   = event_i.timer_ovf;
        interrupt_flags_d = interrupt_flags_q;
        // software only clears: writing 0 clears, writing 1 keeps
        if (reg_wr && hit(req_i, 1'b0, ppc_pkg::REG_IRQ_FLAGS))
            interrupt_flags_d = interrupt_flags_q & req_i.wdata;
        // set wins over a clear in the same cycle
        interrupt_flags_d = (interrupt_flags_d | set_v) & ppc_pkg::IRQ_BITS_MASK;
        gie_d = gie_q;
        if (instr_i.disable_interrupts_instr) gie_d = 1'b0;
        if (instr_i.enable_interrupts_instr)  gie_d = 1'b1;
        // any enabled, masked flag with global enable raises the request
        irq_d = gie_q && ((interrupt_flags_q & interrupt_mask_q) != ppc_pkg::RST_ZERO);
        wake_now = (state_q == PPC_SLEEP) && wake_control_q[ppc_pkg::BIT_WAKE_EN] && change_seen;
        state_d    = state_q;
        wake_d     = 1'b0;
        wake_vec_d = 1'b0;
        unique case (state_q)
            PPC_RUN: begin
                if (instr_i.sleep) state_d = PPC_SLEEP;
            end
            PPC_SLEEP: begin
                if (wake_now) begin
                    state_d    = PPC_RUN;
                    wake_d     = 1'b1;
                    // vector only with mask bit and global enable; else next instruction
                    wake_vec_d = interrupt_mask_q[ppc_pkg::BIT_PORT_CHANGE] & gie_q;
                end
            end
            default: state_d = PPC_RUN;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            interrupt_flags_q <= ppc_pkg::RST_ZERO;
            gie_q      <= 1'b0;
            state_q    <= PPC_RUN;
            irq_q      <= 1'b0;
            wake_q     <= 1'b0;
            wake_vec_q <= 1'b0;
        end else begin
            interrupt_flags_q <= interrupt_flags_d;
            gie_q      <= gie_d;
            state_q    <= state_d;
            irq_q      <= irq_d;
            wake_q     <= wake_d;
            wake_vec_q <= wake_vec_d;
        end
    end

    // pad drive, pulls and read data
    always_comb begin
        p5_out_d  = p5_dat_q;
        p5_oe_n_d = p5_dir_q;
        for (int i = 0; i < ppc_pkg::P6_W; i++) begin
            if (open_drain_control_q[i]) begin
                p6_out_d[i]  = 1'b0;
                p6_oe_n_d[i] = od_oe_n(p6_dir_q[i], p6_dat_q[i]);
            end else begin
                p6_out_d[i]  = p6_dat_q[i];
                p6_oe_n_d[i] = p6_dir_q[i];
            end
        end
        // port 7 never drives high; an external pull-up is needed
        for (int i = 0; i < ppc_pkg::P7_W; i++) begin
            p7_out_d[i]  = 1'b0;
            p7_oe_n_d[i] = od_oe_n(p7_dir_q[i], p7_dat_q[i]);
        end
        p6_pd_d = ~pull_down_control_q[ppc_pkg::PD_P6_LSB +: ppc_pkg::PD_PINS];
        p5_pd_d = ~pull_down_control_q[ppc_pkg::PD_P5_LSB +: ppc_pkg::PD_PINS];
        p6_pu_d = ~pull_high_control_q[ppc_pkg::P6_W-1:0];
        rdata_d = ppc_pkg::RST_ZERO;
        if (ctl_rd) begin
            unique case (req_i.sel)
                ppc_pkg::CTL_PORT5_DIR:  rdata_d[ppc_pkg::P5_W-1:0] = p5_dir_q;
                ppc_pkg::CTL_PORT6_DIR:  rdata_d[ppc_pkg::P6_W-1:0] = p6_dir_q;
                ppc_pkg::CTL_PORT7_DIR:  rdata_d[ppc_pkg::P7_W-1:0] = p7_dir_q;
                ppc_pkg::CTL_PULL_DOWN:  rdata_d = pull_down_control_q;
                ppc_pkg::CTL_OPEN_DRAIN: rdata_d = open_drain_control_q;
                ppc_pkg::CTL_PULL_HIGH:  rdata_d = pull_high_control_q;
                ppc_pkg::CTL_IRQ_MASK:   rdata_d = interrupt_mask_q;
                default:                 rdata_d = ppc_pkg::RST_ZERO;
            endcase
        end else if (reg_rd) begin
            // port reads return the pin level, not the data latch
            unique case (req_i.sel)
                ppc_pkg::REG_PORT5:     rdata_d[ppc_pkg::P5_W-1:0] = p5_in_i;
                ppc_pkg::REG_PORT6:     rdata_d[ppc_pkg::P6_W-1:0] = p6_in_i;
                ppc_pkg::REG_PORT7:     rdata_d[ppc_pkg::P7_W-1:0] = p7_in_i;
                ppc_pkg::REG_WAKE_CTL:  rdata_d = wake_control_q;
                ppc_pkg::REG_IRQ_FLAGS: rdata_d = interrupt_flags_q & interrupt_mask_q;
                default:                rdata_d = ppc_pkg::RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rdata_q   <= ppc_pkg::RST_ZERO;
            p5_out_q  <= ppc_pkg::RST_ZERO[ppc_pkg::P5_W-1:0];
            p5_oe_n_q <= ppc_pkg::RST_DIR[ppc_pkg::P5_W-1:0];
            p6_out_q  <= ppc_pkg::RST_ZERO[ppc_pkg::P6_W-1:0];
            p6_oe_n_q <= ppc_pkg::RST_DIR[ppc_pkg::P6_W-1:0];
            p7_out_q  <= ppc_pkg::RST_ZERO[ppc_pkg::P7_W-1:0];
            p7_oe_n_q <= ppc_pkg::RST_DIR[ppc_pkg::P7_W-1:0];
            p5_pd_q   <= ppc_pkg::RST_ZERO[ppc_pkg::PD_PINS-1:0];
            p6_pd_q   <= ppc_pkg::RST_ZERO[ppc_pkg::PD_PINS-1:0];
            p6_pu_q   <= ppc_pkg::RST_ZERO[ppc_pkg::P6_W-1:0];
        end else begin
            rdata_q   <= rdata_d;
            p5_out_q  <= p5_out_d;
            p5_oe_n_q <= p5_oe_n_d;
            p6_out_q  <= p6_out_d;
            p6_oe_n_q <= p6_oe_n_d;
            p7_out_q  <= p7_out_d;
            p7_oe_n_q <= p7_oe_n_d;
            p5_pd_q   <= p5_pd_d;
            p6_pd_q   <= p6_pd_d;
            p6_pu_q   <= p6_pu_d;
        end
    end

    // outputs straight from flops, except asleep_o, decoded from state_q
    assign rdata_o           = rdata_q;
    assign p5_out_o          = p5_out_q;
    assign p5_oe_n_o         = p5_oe_n_q;
    assign p6_out_o          = p6_out_q;
    assign p6_oe_n_o         = p6_oe_n_q;
    assign p7_out_o          = p7_out_q;
    assign p7_oe_n_o         = p7_oe_n_q;
    assign p5_pull_down_en_o = p5_pd_q;
    assign p6_pull_down_en_o = p6_pd_q;
    assign p6_pull_up_en_o   = p6_pu_q;
    assign irq_o             = irq_q;
    assign asleep_o          = (state_q == PPC_SLEEP);
    assign wake_o            = wake_q;
    assign wake_vector_o     = wake_vec_q;
endmodule // ppc_port

// file: testbench/ppc_port_monitor.sv
// assertion checker for the port pad config block
`timescale 1ns/1ps
module ppc_port_monitor (
    input wire logic                mclk_i,
    input wire logic                rst_n_i,
    input wire ppc_pkg::ppc_req_t   req_i,
    input wire ppc_pkg::ppc_instr_t instr_i,
    input wire logic [7:0]          rdata_o,
    input wire logic [7:0]          p5_oe_n_o,
    input wire logic [7:0]          p6_out_o,
    input wire logic [0:0]          p7_out_o,
    input wire logic [0:0]          p7_oe_n_o,
    input wire logic [3:0]          p5_pull_down_en_o,
    input wire logic [3:0]          p6_pull_down_en_o,
    input wire logic [7:0]          p6_pull_up_en_o,
    input wire logic                irq_o,
    input wire logic                asleep_o,
    input wire logic                wake_o
);
    // control-space write decode; pins lag the register by one edge, hence ##2
    wire logic wc = req_i.wr && req_i.ctl_space;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    pd_pins_a: assert property (wc && req_i.sel == ppc_pkg::CTL_PULL_DOWN |-> ##2
        {p6_pull_down_en_o, p5_pull_down_en_o} == ~$past(req_i.wdata, 2)) else $error("pull-down pins wrong");
    ph_pins_a: assert property (wc && req_i.sel == ppc_pkg::CTL_PULL_HIGH |-> ##2
        p6_pull_up_en_o == ~$past(req_i.wdata, 2)) else $error("pull-up pins wrong");
    dir_pins_a: assert property (wc && req_i.sel == ppc_pkg::CTL_PORT5_DIR |-> ##2
        p5_oe_n_o == $past(req_i.wdata, 2)) else $error("port 5 enables wrong");
    od_low_a: assert property (wc && req_i.sel == ppc_pkg::CTL_OPEN_DRAIN && req_i.wdata == 8'hFF |-> ##2
        p6_out_o == 8'h00) else $error("open-drain pin driven high");
    p7_drain_a: assert property (!p7_oe_n_o[0] |-> !p7_out_o[0]) else $error("port 7 driven high");
    mask_rb_a: assert property (wc && req_i.sel == ppc_pkg::CTL_IRQ_MASK ##1
        (req_i.rd && req_i.ctl_space && req_i.sel == ppc_pkg::CTL_IRQ_MASK) |=>
        rdata_o == ($past(req_i.wdata, 2) & ppc_pkg::IRQ_BITS_MASK)) else $error("mask readback wrong");
    rd_idle_a: assert property (!$past(req_i.rd) |-> rdata_o == 8'h00) else $error("read data not idle");
    mask_off_a: assert property (wc && req_i.sel == ppc_pkg::CTL_IRQ_MASK && req_i.wdata == 8'h00 |-> ##2
        !irq_o) else $error("irq with mask clear");
    gie_off_a: assert property (instr_i.disable_interrupts_instr && !instr_i.enable_interrupts_instr |-> ##2 !irq_o) else $error("irq after disable");
    sleep_in_a: assert property (instr_i.sleep && !asleep_o |=> asleep_o) else $error("sleep not entered");
    wake_once_a: assert property (wake_o |-> $past(asleep_o) ##1 !wake_o) else $error("wake pulse wrong");
endmodule // ppc_port_monitor

// file: testbench/ppc_pins.sv
// external circuits on the port pins
`timescale 1ns/1ps
module ppc_pins (
    input  wire logic [7:0] p5_out_i,
    input  wire logic [7:0] p5_oe_n_i,
    input  wire logic [7:0] p6_out_i,
    input  wire logic [7:0] p6_oe_n_i,
    input  wire logic [0:0] p7_out_i,
    input  wire logic [0:0] p7_oe_n_i,
    input  wire logic [7:0] ext5_i,
    input  wire logic [7:0] ext6_i,
    output logic [7:0]      p5_o,
    output logic [7:0]      p6_o,
    output logic [0:0]      p7_o
);
    // a released pin follows the outside circuit, a driven one the device
    assign p5_o = (p5_oe_n_i & ext5_i) | (~p5_oe_n_i & p5_out_i);
    assign p6_o = (p6_oe_n_i & ext6_i) | (~p6_oe_n_i & p6_out_i);
    // outside resistor lifts port 7 whenever the device lets go
    assign p7_o = p7_oe_n_i[0] ? 1'b1 : p7_out_i;
endmodule // ppc_pins

// file: testbench/ppc_port_test.sv
// self-checking bench for the port pad config block
`timescale 1ns/1ps
module ppc_port_test;
    logic                mclk_i = 1'b0;
    logic                rst_n_i = 1'b0;
    ppc_pkg::ppc_req_t   req_i = '0;
    ppc_pkg::ppc_instr_t instr_i = '0;
    ppc_pkg::ppc_event_t event_i = '0;
    logic [7:0]          ext5 = 8'h3C;
    logic [7:0]          ext6 = 8'h5A;
    logic [7:0]          p5_pin, p6_pin, rdata, p5_out, p5_oe_n, p6_out, p6_oe_n, p6_pu;
    logic [3:0]          p5_pd, p6_pd;
    logic [0:0]          p7_pin, p7_out, p7_oe_n;
    logic                irq, asleep, wake, wvec;
    int                  bad_count = 0;
    int                  num_checks = 0;
    // 200 MHz core clock
    always #2.5 mclk_i = ~mclk_i;
    ppc_port DUT (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req_i), .instr_i(instr_i), .event_i(event_i),
        .p5_in_i(p5_pin), .p6_in_i(p6_pin), .p7_in_i(p7_pin), .rdata_o(rdata), .p5_out_o(p5_out),
        .p5_oe_n_o(p5_oe_n), .p6_out_o(p6_out), .p6_oe_n_o(p6_oe_n), .p7_out_o(p7_out), .p7_oe_n_o(p7_oe_n),
        .p5_pull_down_en_o(p5_pd), .p6_pull_down_en_o(p6_pd), .p6_pull_up_en_o(p6_pu), .irq_o(irq),
        .asleep_o(asleep), .wake_o(wake), .wake_vector_o(wvec));
    ppc_pins PINS (
        .p5_out_i(p5_out), .p5_oe_n_i(p5_oe_n), .p6_out_i(p6_out), .p6_oe_n_i(p6_oe_n), .p7_out_i(p7_out),
        .p7_oe_n_i(p7_oe_n), .ext5_i(ext5), .ext6_i(ext6), .p5_o(p5_pin), .p6_o(p6_pin), .p7_o(p7_pin));
    // compare one result, counting every check
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one access per cycle; the request is left up so no signal is set twice in a step
    task automatic acc(input logic c, input logic w, input logic [3:0] s, input logic [7:0] d);
        req_i = '{ctl_space: c, wr: w, rd: ~w, sel: s, wdata: d};
        @(negedge mclk_i);
    endtask
    task automatic rd(input logic c, input logic [3:0] s, input logic [7:0] exp);
        acc(c, 1'b0, s, 8'h00);
        chk(rdata, exp);
    endtask
    task automatic idle(input int n);
        req_i = '0;
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic pulse(input logic [2:0] in, input logic [2:0] ev);
        req_i = '0;
        instr_i = in;
        event_i = ev;
        @(negedge mclk_i);
        instr_i = '0;
        event_i = '0;
        @(negedge mclk_i);
    endtask
    // snapshot port 6, then drop any pending flags
    task automatic sync6;
        rd(1'b0, ppc_pkg::REG_PORT6, ext6);
        acc(1'b0, 1'b1, ppc_pkg::REG_IRQ_FLAGS, 8'h00);
        idle(1);
    endtask
    function automatic logic [7:0] masked(input logic [7:0] v);
        return v & ppc_pkg::IRQ_BITS_MASK;
    endfunction
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // hang guard: the sequence needs well under a thousand cycles
    initial begin
        #(5 * 4000);
        bad_count++;
        finish_test();
    end
    // main sequence, inputs move on the falling edge
    initial begin
        logic [3:0] sl [6];
        logic [7:0] rv [6];
        logic [7:0] fb [3];
        logic [7:0] d;
        int         n;
        sl = '{ppc_pkg::CTL_PULL_DOWN, ppc_pkg::CTL_OPEN_DRAIN, ppc_pkg::CTL_PULL_HIGH,
               ppc_pkg::CTL_IRQ_MASK, ppc_pkg::CTL_PORT5_DIR, ppc_pkg::CTL_PORT6_DIR};
        rv = '{ppc_pkg::RST_PULL_DOWN, ppc_pkg::RST_OPEN_DRAIN, ppc_pkg::RST_PULL_HIGH,
               ppc_pkg::RST_IRQ_MASK, ppc_pkg::RST_DIR, ppc_pkg::RST_DIR};
        fb = '{8'h80, 8'h04, 8'h01};
        d = 8'($urandom(83));
        repeat (16) @(negedge mclk_i);
        rst_n_i = 1'b1;
        for (int i = 0; i < 6; i++) rd(1'b1, sl[i], rv[i]);
        // first pass alternates all-zero and all-one corners across the registers, then random data
        for (int k = 0; k < 30; k++) begin
            d = (k < 6) ? ((k % 2) ? 8'hFF : 8'h00) : 8'($urandom);
            if (k % 6 == 3) d = masked(d);
            acc(1'b1, 1'b1, sl[k % 6], d);
            rd(1'b1, sl[k % 6], d);
            if (k % 6 == 0) chk({p6_pd, p5_pd}, ~d);
            if (k % 6 == 2) chk(p6_pu, ~d);
            if (k % 6 == 4) chk(p5_oe_n, d);
        end
        acc(1'b1, 1'b1, 4'h9, 8'hFF);
        rd(1'b1, 4'h9, 8'h00);
        // port 5 driven against the outside; port 7 only ever pulls low
        d = 8'($urandom);
        ext5 = ~d;
        acc(1'b1, 1'b1, ppc_pkg::CTL_PORT5_DIR, 8'h00);
        acc(1'b0, 1'b1, ppc_pkg::REG_PORT5, d);
        acc(1'b1, 1'b1, ppc_pkg::CTL_PORT7_DIR, 8'h00);
        acc(1'b0, 1'b1, ppc_pkg::REG_PORT7, 8'h01);
        idle(1);
        rd(1'b0, ppc_pkg::REG_PORT5, d);
        chk(p7_oe_n, 1'b1);
        acc(1'b0, 1'b1, ppc_pkg::REG_PORT7, 8'h00);
        idle(1);
        chk({p7_oe_n, p7_out}, 2'b00);
        // open-drain port 6 never drives high, push-pull does
        acc(1'b1, 1'b1, ppc_pkg::CTL_PORT6_DIR, 8'h00);
        acc(1'b1, 1'b1, ppc_pkg::CTL_OPEN_DRAIN, 8'hFF);
        acc(1'b0, 1'b1, ppc_pkg::REG_PORT6, 8'h0F);
        idle(1);
        chk(p6_out, 8'h00);
        chk(p6_oe_n, 8'h0F);
        acc(1'b1, 1'b1, ppc_pkg::CTL_OPEN_DRAIN, 8'h00);
        idle(1);
        chk(p6_out, 8'h0F);
        chk(p6_oe_n, 8'h00);
        // each of the three event sources sets its own flag; irq follows mask and global enable
        acc(1'b1, 1'b1, ppc_pkg::CTL_PORT6_DIR, 8'hFF);
        acc(1'b1, 1'b1, ppc_pkg::CTL_IRQ_MASK, ppc_pkg::IRQ_BITS_MASK);
        idle(1);
        sync6();
        pulse(3'b100, 3'b000);
        for (int i = 0; i < 3; i++) begin
            pulse(3'b000, 3'b100 >> i);
            chk(irq, 1'b1);
            rd(1'b0, ppc_pkg::REG_IRQ_FLAGS, fb[i]);
            acc(1'b0, 1'b1, ppc_pkg::REG_IRQ_FLAGS, 8'h00);
            idle(2);
            chk(irq, 1'b0);
        end
        acc(1'b1, 1'b1, ppc_pkg::CTL_IRQ_MASK, 8'h00);
        pulse(3'b000, 3'b001);
        chk(irq, 1'b0);
        rd(1'b0, ppc_pkg::REG_IRQ_FLAGS, 8'h00);
        acc(1'b1, 1'b1, ppc_pkg::CTL_IRQ_MASK, 8'h01);
        idle(1);
        chk(irq, 1'b1);
        pulse(3'b010, 3'b000);
        chk(irq, 1'b0);
        // a port 6 change against the last read raises the change flag
        pulse(3'b100, 3'b000);
        acc(1'b1, 1'b1, ppc_pkg::CTL_IRQ_MASK, 8'h02);
        sync6();
        idle(2);
        chk(irq, 1'b0);
        ext6 = ext6 ^ (8'h01 << ($urandom % 8));
        idle(3);
        chk(irq, 1'b1);
        rd(1'b0, ppc_pkg::REG_IRQ_FLAGS, 8'h02);
        // sleep, then wake on a change: vector only with mask bit and global enable
        acc(1'b0, 1'b1, ppc_pkg::REG_WAKE_CTL, 8'h40);
        for (int c = 0; c < 3; c++) begin
            acc(1'b1, 1'b1, ppc_pkg::CTL_IRQ_MASK, (c == 2) ? 8'h00 : 8'h02);
            sync6();
            pulse((c == 1) ? 3'b010 : 3'b100, 3'b000);
            pulse(3'b001, 3'b000);
            chk(asleep, 1'b1);
            ext6 = ~ext6;
            n = 0;
            while (wake !== 1'b1 && n < 10) begin
                @(negedge mclk_i);
                n++;
            end
            chk(wake, 1'b1);
            chk(wvec, c == 0);
            idle(2);
        end
        finish_test();
    end
endmodule // ppc_port_test
bind ppc_port ppc_port_monitor MON (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req_i), .instr_i(instr_i), .rdata_o(rdata_o),
    .p5_oe_n_o(p5_oe_n_o), .p6_out_o(p6_out_o), .p7_out_o(p7_out_o), .p7_oe_n_o(p7_oe_n_o),
    .p5_pull_down_en_o(p5_pull_down_en_o), .p6_pull_down_en_o(p6_pull_down_en_o),
    .p6_pull_up_en_o(p6_pull_up_en_o), .irq_o(irq_o), .asleep_o(asleep_o), .wake_o(wake_o));
